// ===== verilog/clock_ctrl_consts.svh
// Offsets, field positions, reset values and codes of the clock divisor control block
`ifndef CLOCK_CTRL_CONSTS_SVH
`define CLOCK_CTRL_CONSTS_SVH

`define REG_ADDR_W                   12
`define CLOCK_DIVISOR_CONTROL_OFFSET 12'h000
`define CLOCK_STATUS_OFFSET          12'h004

`define CTRL_RECOVER_BIT             15
`define CTRL_DOZE_RATIO_LSB          12
`define CTRL_DOZE_ENABLE_BIT         11
`define CTRL_FAST_RC_LSB             8
`define CTRL_PLL_OUT_DIV_LSB         6
`define CTRL_PLL_IN_PRESCALE_LSB     0
`define CLOCK_DIVISOR_CONTROL_RESET  16'h3040

`define DOZE_RATIO_RESET             3'h3
`define DOZE_RATIO_DIV1              3'h0
`define FAST_RC_DIV256_CODE          3'h7
`define PLL_OUT_DIV8_CODE            2'h3
`define PLL_OUT_RESERVED_CODE        2'h2
`define PLL_OUT_DIV4_CODE            2'h1
`define PLL_OUT_OPEN_CODE            2'h0

`define STATUS_DOZE_ACTIVE_BIT       0
`define STATUS_CPU_LIMIT_LSB         8

`define AXI_RESP_OKAY                2'h0
`define AXI_RESP_SLVERR              2'h2

`endif

// ===== verilog/clock_ctrl_pkg.sv
// Types and shared helper functions of the clock divisor control block
`include "clock_ctrl_consts.svh"
package clock_ctrl_pkg;

  // Field layout of the 16-bit control register, bit 15 first
  typedef struct packed {
    logic       recover_on_interrupt;
    logic [2:0] doze_ratio;
    logic       doze_enable;
    logic [2:0] fast_rc_postscale;
    logic [1:0] pll_output_divider;
    logic       spare;
    logic [4:0] pll_input_prescale;
  } clock_divisor_control_type;

  // One register write, as handed from the bus port to the register file
  typedef struct packed {
    logic                     valid;
    logic [`REG_ADDR_W-1:0]   addr;
    logic [31:0]              data;
    logic [3:0]               strb;
  } reg_write_type;

  // Clock enables that feed the clock tree
  typedef struct packed {
    logic cpu;
    logic peripheral;
    logic fast_rc;
    logic pll;
  } clock_enables_type;

  // Terminal count for a power-of-two processor clock ratio
  function automatic logic [7:0] doze_limit(input logic [2:0] code);
    return (8'h01 << code) - 8'h01;
  endfunction

  // Terminal count of the fast RC postscaler; top code skips 128 for 256
  function automatic logic [7:0] fast_rc_limit(input logic [2:0] code);
    if (code == `FAST_RC_DIV256_CODE) begin
      return 8'hff;
    end
    return (8'h01 << code) - 8'h01;
  endfunction

  // Decoded register addresses; anything else answers with an error
  function automatic logic addr_mapped(input logic [`REG_ADDR_W-1:0] addr);
    return (addr == `CLOCK_DIVISOR_CONTROL_OFFSET) || (addr == `CLOCK_STATUS_OFFSET);
  endfunction

endpackage

// ===== verilog/tick_divider.sv
// Counts source ticks and emits one registered tick every limit+1 of them
`timescale 1ns/100ps
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] limit,
  output logic              tick_q
);

  logic [W-1:0] count_q;

  // Greater-or-equal, so a limit that shrinks mid-count ends the period at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (src_tick) begin
      if (count_q >= limit) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + W'(1);
      end
    end
  end

  // Output tick one cycle after the source tick that completes the period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= src_tick && (count_q >= limit);
    end
  end

endmodule // tick_divider

// ===== verilog/axi_lite_port.sv
// AXI4-Lite slave port that turns bus transfers into register writes and reads
`timescale 1ns/100ps
module axi_lite_port
  import clock_ctrl_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [`REG_ADDR_W-1:0]  awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [`REG_ADDR_W-1:0]  araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output clock_ctrl_pkg::reg_write_type reg_wr_q,
  output logic [`REG_ADDR_W-1:0]       rd_addr,
  input  wire logic [31:0]             rd_data
);

  logic                   aw_full_q;
  logic                   w_full_q;
  logic [`REG_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   commit;

  // Address and data are taken independently; neither while a response waits
  assign awready = !aw_full_q && !bvalid;
  assign wready  = !w_full_q && !bvalid;
  assign commit  = aw_full_q && w_full_q && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // Write address holding stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (commit) begin
      aw_full_q <= 1'b0;
    end
  end

  // Write data holding stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (commit) begin
      w_full_q <= 1'b0;
    end
  end

  // Write strobe to the registers and the response, both on the commit edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_q <= '0;
      bvalid   <= 1'b0;
      bresp    <= `AXI_RESP_OKAY;
    end else begin
      reg_wr_q.valid <= commit && addr_mapped(awaddr_q);
      reg_wr_q.addr  <= awaddr_q;
      reg_wr_q.data  <= wdata_q;
      reg_wr_q.strb  <= wstrb_q;
      if (commit) begin
        bvalid <= 1'b1;
        bresp  <= addr_mapped(awaddr_q) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read answer is captured on the address edge and held until taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `AXI_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= addr_mapped(araddr) ? rd_data : 32'h0000_0000;
      rresp  <= addr_mapped(araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // axi_lite_port

// ===== verilog/clock_divisor_doze_control.sv
// Clock divisor and doze control: control register, clock enables and bus port
//
// Behaviour
// - With recover-on-interrupt set an interrupt clears doze enable, otherwise it is untouched.
// - The 3-bit doze ratio divides the processor clock by 2**code, 1 to 128, resetting to 8.
// - With doze enable set the processor clock runs slower than peripherals by that ratio.
// - Writes to the doze ratio are kept only while doze enable is clear.
// - Setting doze enable while the doze ratio is 000 is ignored and doze enable stays clear.
// - The fast RC postscaler divides by 1,2,4,8,16,32,64,256 for codes 0..7, resetting to 1.
// - The PLL output divider divides by 8 for 11 and 4 for 01 (reset), and 10 is reserved.
`timescale 1ns/100ps
module clock_divisor_doze_control
  import clock_ctrl_pkg::*;
#(
  parameter int         PLL_DIV_W        = 3,
  parameter logic [2:0] PLL_CODE0_LIMIT  = 3'h1
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [`REG_ADDR_W-1:0]      awaddr,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic [1:0]                       bresp,
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [`REG_ADDR_W-1:0]      araddr,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  input  wire logic                        interrupt_event,
  input  wire logic                        fast_rc_osc_tick,
  input  wire logic                        pll_vco_tick,
  output clock_ctrl_pkg::clock_enables_type clock_enables,
  output logic [4:0]                       pll_input_prescale,
  output logic                             doze_active
);
  import clock_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus port

  reg_write_type             reg_wr_q;
  logic [`REG_ADDR_W-1:0]    rd_addr;
  logic [31:0]               rd_data;
  clock_divisor_control_type ctrl_q;
  clock_divisor_control_type ctrl_d;
  clock_divisor_control_type wr_fields;
  logic [15:0]               wr_word;
  logic [7:0]                cpu_limit;
  logic [7:0]                fast_rc_lim;
  logic [PLL_DIV_W-1:0]      pll_limit;
  logic                      cpu_tick_q;
  logic                      periph_tick_q;
  logic                      fast_rc_tick_q;
  logic                      pll_tick_q;

  axi_lite_port u_port (
    .clk      (clk),
    .rst      (rst),
    .awvalid  (awvalid),
    .awready  (awready),
    .awaddr   (awaddr),
    .wvalid   (wvalid),
    .wready   (wready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .bvalid   (bvalid),
    .bready   (bready),
    .bresp    (bresp),
    .arvalid  (arvalid),
    .arready  (arready),
    .araddr   (araddr),
    .rvalid   (rvalid),
    .rready   (rready),
    .rdata    (rdata),
    .rresp    (rresp),
    .reg_wr_q (reg_wr_q),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes have no storage
  always_comb begin
    wr_word[7:0]  = reg_wr_q.strb[0] ? reg_wr_q.data[7:0] : ctrl_q[7:0];
    wr_word[15:8] = reg_wr_q.strb[1] ? reg_wr_q.data[15:8] : ctrl_q[15:8];
    wr_fields     = clock_divisor_control_type'(wr_word);
  end

  // Next value: write first, interrupt recovery last so it wins a same-cycle set
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr_q.valid && (reg_wr_q.addr == `CLOCK_DIVISOR_CONTROL_OFFSET)) begin
      ctrl_d.recover_on_interrupt = wr_fields.recover_on_interrupt;
      if (!ctrl_q.doze_enable) begin
        ctrl_d.doze_ratio = wr_fields.doze_ratio;
      end
      // Checked against the ratio that this same write leaves behind
      ctrl_d.doze_enable = wr_fields.doze_enable &&
                           (ctrl_d.doze_ratio != `DOZE_RATIO_DIV1);
      ctrl_d.fast_rc_postscale = wr_fields.fast_rc_postscale;
      // Reserved divider code is refused so the PLL never sees it
      if (wr_fields.pll_output_divider != `PLL_OUT_RESERVED_CODE) begin
        ctrl_d.pll_output_divider = wr_fields.pll_output_divider;
      end
      ctrl_d.pll_input_prescale = wr_fields.pll_input_prescale;
      ctrl_d.spare              = 1'b0;
    end
    if (interrupt_event && ctrl_q.recover_on_interrupt) begin
      ctrl_d.doze_enable = 1'b0;
    end
  end

  // Register state, doze ratio 8 and PLL divide by 4 out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= clock_divisor_control_type'(`CLOCK_DIVISOR_CONTROL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables

  // Doze ratio only applies while doze is on; otherwise every cycle ticks
  assign cpu_limit = ctrl_q.doze_enable ? doze_limit(ctrl_q.doze_ratio) : 8'h00;
  assign fast_rc_lim = fast_rc_limit(ctrl_q.fast_rc_postscale);

  // Divide by 8, 4, or for the open code 0 by PLL_CODE0_LIMIT plus one
  always_comb begin
    unique case (ctrl_q.pll_output_divider)
      `PLL_OUT_DIV8_CODE: pll_limit = PLL_DIV_W'(7);
      `PLL_OUT_DIV4_CODE: pll_limit = PLL_DIV_W'(3);
      `PLL_OUT_OPEN_CODE: pll_limit = PLL_DIV_W'(PLL_CODE0_LIMIT);
      default:            pll_limit = PLL_DIV_W'(3);
    endcase
  end

  tick_divider #(.W(8)) u_cpu_div (
    .clk      (clk),
    .rst      (rst),
    .src_tick (1'b1),
    .limit    (cpu_limit),
    .tick_q   (cpu_tick_q)
  );

  tick_divider #(.W(8)) u_fast_rc_div (
    .clk      (clk),
    .rst      (rst),
    .src_tick (fast_rc_osc_tick),
    .limit    (fast_rc_lim),
    .tick_q   (fast_rc_tick_q)
  );

  tick_divider #(.W(PLL_DIV_W)) u_pll_div (
    .clk      (clk),
    .rst      (rst),
    .src_tick (pll_vco_tick),
    .limit    (pll_limit),
    .tick_q   (pll_tick_q)
  );

  // Peripheral clocks always run at the full system rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_tick_q <= 1'b0;
    end else begin
      periph_tick_q <= 1'b1;
    end
  end

  assign clock_enables.cpu        = cpu_tick_q;
  assign clock_enables.peripheral = periph_tick_q;
  assign clock_enables.fast_rc    = fast_rc_tick_q;
  assign clock_enables.pll        = pll_tick_q;
  assign pll_input_prescale       = ctrl_q.pll_input_prescale;
  assign doze_active              = ctrl_q.doze_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Status shows the live doze state and the terminal count in use
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == `CLOCK_DIVISOR_CONTROL_OFFSET) begin
      rd_data[15:0] = ctrl_q;
    end else if (rd_addr == `CLOCK_STATUS_OFFSET) begin
      rd_data[`STATUS_DOZE_ACTIVE_BIT] = ctrl_q.doze_enable;
      rd_data[`STATUS_CPU_LIMIT_LSB +: 8] = cpu_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [7:0] cpu_gap_q;
  logic       settle_q;

  // Cycles since the last processor tick, and a flag while a ratio change settles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_gap_q <= 8'h00;
      settle_q  <= 1'b1;
    end else begin
      cpu_gap_q <= cpu_tick_q ? 8'h01 : cpu_gap_q + 8'h01;
      if (ctrl_d.doze_enable != ctrl_q.doze_enable || ctrl_d.doze_ratio != ctrl_q.doze_ratio) begin
        settle_q <= 1'b1;
      end else if (cpu_tick_q) begin
        settle_q <= 1'b0;
      end
    end
  end

  sequence s_recover_irq;
    ctrl_q.recover_on_interrupt && interrupt_event;
  endsequence

  sequence s_ctrl_write;
    reg_wr_q.valid && (reg_wr_q.addr == `CLOCK_DIVISOR_CONTROL_OFFSET);
  endsequence

  a_irq_clears_doze:
    assert property (@(posedge clk) disable iff (rst) s_recover_irq |=> !ctrl_q.doze_enable)
    else $error("doze enable survived an interrupt with recovery on");

  a_irq_keeps_doze:
    assert property (@(posedge clk) disable iff (rst)
      !ctrl_q.recover_on_interrupt && interrupt_event && !reg_wr_q.valid
      |=> $stable(ctrl_q.doze_enable))
    else $error("interrupt changed doze enable with recovery off");

  a_ratio_after_reset:
    assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> ctrl_q.doze_ratio == 3'h3 && !ctrl_q.doze_enable)
    else $error("doze ratio not 8 after reset");

  a_cpu_tick_gap:
    assert property (@(posedge clk) disable iff (rst)
      cpu_tick_q && !settle_q && ctrl_q.doze_enable
      |-> cpu_gap_q == (8'h01 << ctrl_q.doze_ratio))
    else $error("processor tick spacing does not match the doze ratio");

  a_full_rate_cpu:
    assert property (@(posedge clk) disable iff (rst)
      !ctrl_q.doze_enable ##1 !ctrl_q.doze_enable |=> cpu_tick_q && periph_tick_q)
    else $error("processor clock slower than peripherals with doze off");

  a_ratio_locked:
    assert property (@(posedge clk) disable iff (rst)
      s_ctrl_write ##0 ctrl_q.doze_enable |=> $stable(ctrl_q.doze_ratio))
    else $error("doze ratio changed while doze was on");

  a_no_doze_div1:
    assert property (@(posedge clk) disable iff (rst)
      ctrl_q.doze_enable |-> ctrl_q.doze_ratio != 3'h0)
    else $error("doze enabled with a ratio of one");

  a_fast_rc_div1:
    assert property (@(posedge clk) disable iff (rst)
      ctrl_q.fast_rc_postscale == 3'h0 && $stable(ctrl_q.fast_rc_postscale) &&
      fast_rc_osc_tick |=> fast_rc_tick_q)
    else $error("fast RC postscaler does not pass every tick at code 0");

  a_fast_rc_cause:
    assert property (@(posedge clk) disable iff (rst) fast_rc_tick_q |-> $past(fast_rc_osc_tick))
    else $error("fast RC tick without an oscillator tick");

  a_pll_reserved:
    assert property (@(posedge clk) disable iff (rst)
      ctrl_q.pll_output_divider != 2'h2 ##0 $past(ctrl_q.pll_output_divider) != 2'h2)
    else $error("PLL output divider holds the reserved code");

endmodule // clock_divisor_doze_control

// ===== sim/clock_divisor_doze_control_bench.sv
// Self-checking bench for the clock divisor and doze control block
`timescale 1ns/100ps
`include "clock_ctrl_consts.svh"
module clock_divisor_doze_control_bench;
  import clock_ctrl_pkg::*;

  localparam logic [2:0]             CODE0_LIM = 3'h1;
  localparam int                     CEILING   = 40000;
  localparam logic [`REG_ADDR_W-1:0] CTRL      = `CLOCK_DIVISOR_CONTROL_OFFSET;
  localparam logic [`REG_ADDR_W-1:0] STAT      = `CLOCK_STATUS_OFFSET;
  localparam logic [1:0]             OK        = `AXI_RESP_OKAY;

  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
    int          internal_fast_rc_oscillator;
    int          pll;
  } row_type;

  // Doze off in every row; fast RC ticks every 2nd cycle, VCO every 3rd
  localparam row_type ROWS [8] = '{
    '{16'h0040, 16'h0040, 2, 12}, '{16'h11c5, 16'h11c5, 4, 24},
    '{16'h2280, 16'h22c0, 8, 24}, '{16'h331f, 16'h331f, 16, 3 * (CODE0_LIM + 1)},
    '{16'h4440, 16'h4440, 32, 12}, '{16'h5540, 16'h5540, 64, 12},
    '{16'h6640, 16'h6640, 128, 12}, '{16'h7760, 16'h7740, 512, 12}};

  logic                   clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic                   interrupt_event, fast_rc_osc_tick, pll_vco_tick;
  logic                   awready, wready, bvalid, arready, rvalid, doze_active;
  logic [`REG_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb, ce_bits;
  logic [1:0]             bresp, rresp;
  logic [4:0]             pll_input_prescale;
  clock_enables_type      clock_enables;
  int                     err_count, total_checks, cycles, tick_cnt, per;

  assign ce_bits = clock_enables;

  clock_divisor_doze_control #(
    .PLL_DIV_W       (3),
    .PLL_CODE0_LIMIT (CODE0_LIM)
  ) u_clock_divisor_doze_control (
    .clk (clk), .rst (rst), .awvalid (awvalid), .awready (awready), .awaddr (awaddr),
    .wvalid (wvalid), .wready (wready), .wdata (wdata), .wstrb (wstrb),
    .bvalid (bvalid), .bready (bready), .bresp (bresp), .arvalid (arvalid),
    .arready (arready), .araddr (araddr), .rvalid (rvalid), .rready (rready),
    .rdata (rdata), .rresp (rresp), .interrupt_event (interrupt_event),
    .fast_rc_osc_tick (fast_rc_osc_tick), .pll_vco_tick (pll_vco_tick),
    .clock_enables (clock_enables), .pll_input_prescale (pll_input_prescale),
    .doze_active (doze_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, oscillator ticks and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ticks slower than clk so the dividers must count ticks, not cycles
  always @(posedge clk) begin
    tick_cnt         <= (tick_cnt == 5) ? 0 : tick_cnt + 1;
    fast_rc_osc_tick <= (tick_cnt % 2) == 0;
    pll_vco_tick     <= (tick_cnt % 3) == 0;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      err_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [`REG_ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er = OK);
    logic       aw_p, w_p, a_s, w_s;
    logic [1:0] resp;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    while (aw_p || w_p) begin
      @(negedge clk);
      a_s = awready;
      w_s = wready;
      @(posedge clk);
      if (aw_p && a_s === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && w_s === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
    // Register lands on this edge; let it settle before anyone looks
    @(negedge clk);
    check("bresp", resp, er);
  endtask

  task automatic rd_chk(input string nm, input logic [`REG_ADDR_W-1:0] a,
                        input logic [31:0] exp, input logic [1:0] er = OK);
    logic        a_s;
    logic [31:0] d;
    logic [1:0]  resp;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      a_s = arready;
      @(posedge clk);
    end while (a_s !== 1'b1);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d    = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
    @(negedge clk);
    check(nm, d, exp);
    check("rresp", resp, er);
  endtask

  // First period after a change may be cut short, so skip it
  task automatic measure(input int sel, output int p);
    do @(negedge clk); while (ce_bits[sel] !== 1'b1);
    do @(negedge clk); while (ce_bits[sel] !== 1'b1);
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (ce_bits[sel] !== 1'b1);
  endtask

  task automatic pulse_irq();
    @(posedge clk);
    interrupt_event <= 1'b1;
    @(posedge clk);
    interrupt_event <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3f & 6'h20;
    {interrupt_event, fast_rc_osc_tick, pll_vco_tick} = 3'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {err_count, total_checks, cycles, tick_cnt} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk("reset value", CTRL, 32'h3040);
    check("doze after reset", doze_active, 1'b0);
    // Postscaler, output divider and equal clocks with doze off
    foreach (ROWS[i]) begin
      wr(CTRL, ROWS[i].wr);
      rd_chk("control", CTRL, ROWS[i].rd);
      check("prescale", pll_input_prescale, ROWS[i].rd[4:0]);
      measure(1, per);
      check("fast rc period", per, ROWS[i].internal_fast_rc_oscillator);
      measure(0, per);
      check("pll period", per, ROWS[i].pll);
      measure(3, per);
      check("cpu period doze off", per, 1);
    end
    // Doze ratios 2 to 128, then a discarded ratio write while dozing
    for (int r = 1; r < 8; r++) begin
      wr(CTRL, {16'h0, 1'b0, r[2:0], 12'h040});
      wr(CTRL, {16'h0, 1'b0, r[2:0], 12'h840});
      check("doze active", doze_active, 1'b1);
      measure(3, per);
      check("cpu period doze on", per, 1 << r);
      measure(2, per);
      check("peripheral period", per, 1);
      wr(CTRL, {16'h0, 1'b0, r[2:0] + 3'h1, 12'h840});
      rd_chk("ratio held", CTRL, {16'h0, 1'b0, r[2:0], 12'h840});
      wr(CTRL, 32'h0040);
      rd_chk("ratio kept", CTRL, {16'h0, 1'b0, r[2:0], 12'h040});
    end
    wr(CTRL, 32'h0840);
    rd_chk("doze refused", CTRL, 32'h0040);
    check("doze stays off", doze_active, 1'b0);
    // Interrupt ends doze only with recovery armed
    wr(CTRL, 32'h3040);
    wr(CTRL, 32'hb840);
    rd_chk("status", STAT, 32'h0701);
    pulse_irq();
    rd_chk("recover clears", CTRL, 32'hb040);
    check("doze after irq", doze_active, 1'b0);
    wr(CTRL, 32'h3840);
    pulse_irq();
    rd_chk("no recover", CTRL, 32'h3840);
    // Unmapped and read-only places leave the control register alone
    wr(12'h008, 32'hffff, `AXI_RESP_SLVERR);
    rd_chk("unmapped", 12'h008, 32'h0, `AXI_RESP_SLVERR);
    wr(STAT, 32'h0);
    rd_chk("after stray writes", CTRL, 32'h3840);
    // Reset in mid-run while dozing, raised on a rising edge like every input
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("doze after second reset", doze_active, 1'b0);
    rd_chk("reset value again", CTRL, 32'h3040);
    end_sim();
  end

endmodule // clock_divisor_doze_control_bench
